/* rtl/diag_prefetch_regs.vh */
// register offsets, fields, reset values and prefetch constants
`ifndef DIAG_PREFETCH_REGS_VH
`define DIAG_PREFETCH_REGS_VH
`define CDZ_OFFSET 8'hC0
`define CDZ_RESET 32'h00000000
`define CDZ_BUS_HI 31
`define CDZ_BUS_LO 24
`define CDZ_DEV_HI 23
`define CDZ_DEV_LO 19
`define CDZ_RSVA_HI 15
`define CDZ_RSVA_LO 14
`define CDZ_RSVB_HI 11
`define CDZ_RSVB_LO 8
`define CDZ_QUAD_BIT 6
`define CDZ_LOW_HI 5
`define CDZ_LOW_LO 0
`define RW_MASK 32'h0000CF7F
`define BUS_RESET 8'h00
`define DEV_RESET 5'h00
`define ZERO_DW 16'h0000
`define LINES_TWO 3'h2
`define LINES_FOUR 3'h4
`define ONE_DWORD 16'h0001
`define CLS_WIDTH 8
`define RSVA_RESET 2'h0
`define RSVB_RESET 4'h0
`define LOW_RESET 6'h00
`define FLAG_RESET 1'h0
`define RO_ZERO3 3'h0
`define RO_ZERO2 2'h0
`define RO_ZERO1 1'h0
`endif

/* rtl/prefetch_size_select.v */
// prefetch length selection for upstream memory reads
`timescale 1ns/100ps
module prefetch_size_select (
   input wire clock,
   input wire reset_n,
   input wire quadLinePrefetchEnable,
   input wire forceMultipleReadAll,
   input wire readLookaheadDisable,
   input wire [7:0] cacheLineSize,
   input wire readIsMultiple,
   output reg [15:0] prefetchDwords,
   output reg prefetchOneDword
);
`include "diag_prefetch_regs.vh"
   reg [2:0] lines;
   reg [15:0] next_prefetchDwords;
   reg next_prefetchOneDword;
   always @* begin
      lines = quadLinePrefetchEnable ? `LINES_FOUR : `LINES_TWO;
      next_prefetchOneDword = 1'h0;
      if (readLookaheadDisable) begin
         next_prefetchDwords = `ONE_DWORD;
         next_prefetchOneDword = 1'h1;
      end else if (readIsMultiple || forceMultipleReadAll) begin
         next_prefetchDwords = {5'h00, lines} * {8'h00, cacheLineSize};
      end else begin
         next_prefetchDwords = `ONE_DWORD;
         next_prefetchOneDword = 1'h1;
      end
   end
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prefetchDwords <= `ZERO_DW;
         prefetchOneDword <= `FLAG_RESET;
      end else begin
         prefetchDwords <= next_prefetchDwords;
         prefetchOneDword <= next_prefetchOneDword;
      end
   end
endmodule // prefetch_size_select

/* rtl/bridge_diag_prefetch_control.v */
// control and diagnostic register zero with prefetch steering
`timescale 1ns/100ps
module bridge_diag_prefetch_control (
   input wire clock,
   input wire reset_n,
   input wire cfgWrite,
   input wire cfgRead,
   input wire [7:0] cfgOffset,
   input wire [3:0] cfgByteEnable,
   input wire [31:0] cfgWriteData,
   input wire [7:0] cfgBusNumber,
   input wire [4:0] cfgDeviceNumber,
   input wire forceMultipleReadAll,
   input wire readLookaheadDisable,
   input wire [7:0] cacheLineSize,
   input wire readIsMultiple,
   output reg [31:0] cfgReadData,
   output reg cfgReadHit,
   output reg quadLinePrefetchEnable,
   output wire [15:0] prefetchDwords,
   output wire prefetchOneDword
);
`include "diag_prefetch_regs.vh"
   // ************************************************************
   // storage
   // ************************************************************
   reg [7:0] capturedUpstreamBusNumber;
   reg [4:0] capturedUpstreamDeviceNumber;
   reg [1:0] reservedFieldHigh;
   reg [3:0] reservedFieldLow;
   reg [5:0] lowControl;

   // ************************************************************
   // next values
   // ************************************************************
   reg [7:0] next_capturedUpstreamBusNumber;
   reg [4:0] next_capturedUpstreamDeviceNumber;
   reg [1:0] next_reservedFieldHigh;
   reg [3:0] next_reservedFieldLow;
   reg next_quadLinePrefetchEnable;
   reg [5:0] next_lowControl;
   reg [31:0] next_cfgReadData;
   reg next_cfgReadHit;

   // ************************************************************
   // access decode
   // ************************************************************
   wire writeHit;
   wire readHit;
   wire [31:0] current;
   wire [31:0] merged;

   // true when an access addresses this register
   function offset_match;
      input strobe;
      input [7:0] offset;
      begin
         offset_match = strobe && (offset == `CDZ_OFFSET);
      end
   endfunction

   // byte lanes with enable low keep the old value
   function [31:0] byte_merge;
      input [31:0] oldValue;
      input [31:0] newValue;
      input [3:0] enables;
      integer i;
      begin
         byte_merge = oldValue;
         for (i = 0; i < 4; i = i + 1) begin
            if (enables[i]) begin
               byte_merge[i*8 +: 8] = newValue[i*8 +: 8];
            end
         end
      end
   endfunction

   assign writeHit = offset_match(cfgWrite, cfgOffset);
   assign readHit = offset_match(cfgRead, cfgOffset);
   // reserved read-only bits assemble as zero
   assign current = {capturedUpstreamBusNumber,
      capturedUpstreamDeviceNumber,
      `RO_ZERO3,
      reservedFieldHigh,
      `RO_ZERO2,
      reservedFieldLow,
      `RO_ZERO1,
      quadLinePrefetchEnable,
      lowControl};
   // read-only positions are masked so write data cannot reach them
   assign merged = byte_merge(current, cfgWriteData, cfgByteEnable) & `RW_MASK;

   // ************************************************************
   // write field views
   // ************************************************************
   wire [1:0] writeReservedHigh;
   wire [3:0] writeReservedLow;
   wire writeQuad;
   wire [5:0] writeLowControl;
   assign writeReservedHigh = merged[`CDZ_RSVA_HI:`CDZ_RSVA_LO];
   assign writeReservedLow = merged[`CDZ_RSVB_HI:`CDZ_RSVB_LO];
   assign writeQuad = merged[`CDZ_QUAD_BIT];
   assign writeLowControl = merged[`CDZ_LOW_HI:`CDZ_LOW_LO];

   // ************************************************************
   // captured bus and device number
   // ************************************************************
   always @* begin
      next_capturedUpstreamBusNumber = capturedUpstreamBusNumber;
      next_capturedUpstreamDeviceNumber = capturedUpstreamDeviceNumber;
      if (writeHit) begin
         next_capturedUpstreamBusNumber = cfgBusNumber;
         next_capturedUpstreamDeviceNumber = cfgDeviceNumber;
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         capturedUpstreamBusNumber <= `BUS_RESET;
         capturedUpstreamDeviceNumber <= `DEV_RESET;
      end else begin
         capturedUpstreamBusNumber <= next_capturedUpstreamBusNumber;
         capturedUpstreamDeviceNumber <= next_capturedUpstreamDeviceNumber;
      end
   end

   // ************************************************************
   // writable reserved fields
   // ************************************************************
   always @* begin
      next_reservedFieldHigh = reservedFieldHigh;
      next_reservedFieldLow = reservedFieldLow;
      if (writeHit) begin
         next_reservedFieldHigh = writeReservedHigh;
         next_reservedFieldLow = writeReservedLow;
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reservedFieldHigh <= `RSVA_RESET;
         reservedFieldLow <= `RSVB_RESET;
      end else begin
         reservedFieldHigh <= next_reservedFieldHigh;
         reservedFieldLow <= next_reservedFieldLow;
      end
   end

   // ************************************************************
   // prefetch control and low bits
   // ************************************************************
   always @* begin
      next_quadLinePrefetchEnable = quadLinePrefetchEnable;
      next_lowControl = lowControl;
      if (writeHit) begin
         next_quadLinePrefetchEnable = writeQuad;
         next_lowControl = writeLowControl;
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         quadLinePrefetchEnable <= `FLAG_RESET;
         lowControl <= `LOW_RESET;
      end else begin
         quadLinePrefetchEnable <= next_quadLinePrefetchEnable;
         lowControl <= next_lowControl;
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   always @* begin
      next_cfgReadHit = readHit;
      next_cfgReadData = `CDZ_RESET;
      if (readHit) begin
         next_cfgReadData = current;
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfgReadHit <= `FLAG_RESET;
      end else begin
         cfgReadHit <= next_cfgReadHit;
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfgReadData <= `CDZ_RESET;
      end else begin
         cfgReadData <= next_cfgReadData;
      end
   end

   // ************************************************************
   // prefetch length
   // ************************************************************
   prefetch_size_select i_prefetch_size_select (
      .clock(clock),
      .reset_n(reset_n),
      .quadLinePrefetchEnable(quadLinePrefetchEnable),
      .forceMultipleReadAll(forceMultipleReadAll),
      .readLookaheadDisable(readLookaheadDisable),
      .cacheLineSize(cacheLineSize),
      .readIsMultiple(readIsMultiple),
      .prefetchDwords(prefetchDwords),
      .prefetchOneDword(prefetchOneDword)
   );
endmodule // bridge_diag_prefetch_control

/* tb/upstream_reader.sv */
// upstream read master model
`timescale 1ns/100ps
module upstream_reader (
   input wire clock,
   input wire wantMultiple,
   output reg readIsMultiple
);
   initial readIsMultiple = 1'b0;
   always @(posedge clock) readIsMultiple <= #1 wantMultiple;
endmodule // upstream_reader

/* tb/diag_regs_asserts.sv */
// assertions for the diagnostic register
`timescale 1ns/100ps
module diag_regs_asserts (
   input wire clock,
   input wire reset_n,
   input wire cfgWrite,
   input wire cfgRead,
   input wire [7:0] cfgOffset,
   input wire [7:0] cfgBusNumber,
   input wire forceMultipleReadAll,
   input wire readLookaheadDisable,
   input wire readIsMultiple,
   input wire [7:0] cacheLineSize,
   input wire [31:0] cfgReadData,
   input wire cfgReadHit,
   input wire quadLinePrefetchEnable,
   input wire [15:0] prefetchDwords,
   input wire prefetchOneDword
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence wrHit; cfgWrite && cfgOffset == 8'hC0; endsequence
   sequence rdHit; cfgRead && cfgOffset == 8'hC0; endsequence
   sequence rdOnly; cfgRead && !cfgWrite && cfgOffset == 8'hC0; endsequence
   hit_delay_a: assert property (rdHit |=> cfgReadHit) else $error("no hit");
   miss_zero_a: assert property (!(cfgRead && cfgOffset == 8'hC0)
      |=> !cfgReadHit && cfgReadData == 32'h0) else $error("miss data");
   reserved_field_high_a: assert property (cfgReadHit |-> cfgReadData[18:16] == 3'h0)
      else $error("bits 18:16");
   reserved_field_mid_a: assert property (cfgReadHit |-> cfgReadData[13:12] == 2'h0)
      else $error("bits 13:12");
   reserved_field_bit_a: assert property (cfgReadHit |-> !cfgReadData[7]) else $error("bit 7");
   bus_capture_a: assert property (wrHit ##1 rdOnly
      |=> cfgReadData[31:24] == $past(cfgBusNumber, 2)) else $error("bus number");
   line_count_a: assert property (!readLookaheadDisable && (readIsMultiple ||
      forceMultipleReadAll) |=> prefetchDwords == $past(cacheLineSize)
      * ($past(quadLinePrefetchEnable) ? 16'h0004 : 16'h0002)) else $error("line count");
   one_dword_a: assert property (readLookaheadDisable |=> prefetchOneDword
      && prefetchDwords == 16'h0001) else $error("one dword");
endmodule // diag_regs_asserts
bind bridge_diag_prefetch_control diag_regs_asserts i_diag_regs_asserts (.*);

/* tb/testbench.sv */
// self-checking bench for the diagnostic register
`timescale 1ns/100ps
module testbench;
   reg clock = 0, reset_n = 0, cfgWrite = 0, cfgRead = 0, wantMultiple = 0;
   reg forceMultipleReadAll = 0, readLookaheadDisable = 0;
   reg [7:0] cfgOffset = 8'hC0, cfgBusNumber = 8'hA5, cacheLineSize = 8'h08;
   reg [3:0] cfgByteEnable = 4'hF;
   reg [4:0] cfgDeviceNumber = 5'h13;
   reg [31:0] cfgWriteData = 32'h0;
   wire [31:0] cfgReadData;
   wire [15:0] prefetchDwords;
   wire cfgReadHit, quadLinePrefetchEnable, prefetchOneDword, readIsMultiple;
   integer errorCnt = 0, checks = 0;
   always #10 clock = ~clock;
   bridge_diag_prefetch_control i_bridge_diag_prefetch_control (
      .clock(clock),
      .reset_n(reset_n),
      .cfgWrite(cfgWrite),
      .cfgRead(cfgRead),
      .cfgOffset(cfgOffset),
      .cfgByteEnable(cfgByteEnable),
      .cfgWriteData(cfgWriteData),
      .cfgBusNumber(cfgBusNumber),
      .cfgDeviceNumber(cfgDeviceNumber),
      .forceMultipleReadAll(forceMultipleReadAll),
      .readLookaheadDisable(readLookaheadDisable),
      .cacheLineSize(cacheLineSize),
      .readIsMultiple(readIsMultiple),
      .cfgReadData(cfgReadData),
      .cfgReadHit(cfgReadHit),
      .quadLinePrefetchEnable(quadLinePrefetchEnable),
      .prefetchDwords(prefetchDwords),
      .prefetchOneDword(prefetchOneDword)
   );
   upstream_reader i_upstream_reader (
      .clock(clock),
      .wantMultiple(wantMultiple),
      .readIsMultiple(readIsMultiple)
   );
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            errorCnt = errorCnt + 1;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [3:0] be, input [31:0] d);
      begin
         @(posedge clock) #1 cfgWrite = 1;
         {cfgByteEnable, cfgWriteData} = {be, d};
         @(posedge clock) #1 cfgWrite = 0;
      end
   endtask
   task rd(input [7:0] off, input [31:0] exp);
      begin
         @(posedge clock) #1 cfgRead = 1;
         cfgOffset = off;
         @(posedge clock) #1 cfgRead = 0;
         cfgOffset = 8'hC0;
         chk(cfgReadHit, off == 8'hC0);
         chk(cfgReadData, exp);
      end
   endtask
   task pf(input m, input f, input d, input [15:0] exp);
      begin
         {wantMultiple, forceMultipleReadAll, readLookaheadDisable} = {m, f, d};
         repeat (3) @(posedge clock);
         #1 chk(prefetchDwords, exp);
         chk(prefetchOneDword, exp == 16'h0001);
      end
   endtask
   task reset_state;
      begin
         rd(8'hC0, 32'h0);
         pf(1, 0, 0, 16'h0010);
      end
   endtask
   task full_write;
      begin
         wr(4'hF, 32'hFFFFFFFF);
         chk(quadLinePrefetchEnable, 1);
         rd(8'hC0, 32'hA598CF7F);
         pf(1, 0, 0, 16'h0020);
         pf(0, 1, 0, 16'h0020);
         pf(1, 1, 1, 16'h0001);
      end
   endtask
   task lane_and_miss;
      begin
         {cfgBusNumber, cfgDeviceNumber} = {8'h3C, 5'h04};
         wr(4'h1, 32'h0);
         chk(quadLinePrefetchEnable, 0);
         rd(8'hC0, 32'h3C20CF00);
         rd(8'hC4, 32'h0);
         pf(1, 0, 0, 16'h0010);
         wr(4'hF, 32'h0);
         rd(8'hC0, 32'h3C200000);
      end
   endtask
   task mid_reset;
      begin
         @(posedge clock) #1 reset_n = 0;
         #1 chk(quadLinePrefetchEnable, 0);
         chk(prefetchDwords, 16'h0000);
         chk(cfgReadData, 32'h0);
         repeat (3) @(posedge clock);
         #1 reset_n = 1;
         rd(8'hC0, 32'h0);
         pf(1, 0, 0, 16'h0010);
      end
   endtask
   task end_of_test;
      begin
         $display("errors %0d checks %0d", errorCnt, checks);
         if (errorCnt == 0 && checks > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      #100000 errorCnt = errorCnt + 1;
      end_of_test;
   end
   initial begin
      repeat (10) @(posedge clock);
      #1 reset_n = 1;
      reset_state;
      full_write;
      lane_and_miss;
      mid_reset;
      end_of_test;
   end
endmodule // testbench
